// ==== include/aefu_consts.vh ====
// Constants for the access error frame unit
`ifndef AEFU_CONSTS_VH
`define AEFU_CONSTS_VH
`define AEFU_FRAME_WORDS      8'h1E
`define AEFU_FRAME_BYTES      8'h3C
`define AEFU_FMT_ACCESS       4'h7
`define AEFU_FMT_ADDR_ERR     4'h2
`define AEFU_FMT_FOUR_WORD    4'h0
`define AEFU_FMT_FP_POST      4'h3
`define AEFU_TRACE_SRC_LAST   8'h0B
`define AEFU_TRACE_SHIFT      8'h30
`define AEFU_RETURN_LAST      8'h0D
`define AEFU_MOD_USER_INSN    3'h2
`define AEFU_MOD_SUPER_INSN   3'h6
`define AEFU_MODE_PC_REL      3'h7
`define AEFU_REG_PC_DISP      3'h2
`define AEFU_REG_PC_INDEX     3'h3
`define AEFU_MODE_INDEX       3'h6
`define AEFU_SIZE_BYTE        2'h1
`define AEFU_SIZE_WORD        2'h2
`define AEFU_SIZE_LONG        2'h0
`define AEFU_ST_FP_POST       15
`define AEFU_ST_FP_UNIMPL     14
`define AEFU_ST_TRACE         13
`define AEFU_ST_MULTI_MOVE    12
`define AEFU_ST_PAGE_SPAN     11
`define AEFU_ST_XLATE         10
`define AEFU_ST_LOCKED        9
`define AEFU_ST_READ          8
`define AEFU_ST_SIZE_LO       5
`define AEFU_ST_TYPE_LO       3
`endif

// ==== core/aefu_frame_unit.v ====
// Access error frame builder and exception return interpreter
`include "aefu_consts.vh"
`default_nettype none
module aefu_frame_unit
#(
	parameter AW = 32
)
(
	input  wire          CLOCK,
	input  wire          RST_B,
	input  wire          FAULT_VALID,
	input  wire          FAULT_IS_INSN,
	input  wire          FAULT_IS_PUSH,
	input  wire          FAULT_IS_LINE_MOVE_WR,
	input  wire          FAULT_IS_TRANSLATION,
	input  wire          FAULT_SECOND_PAGE,
	input  wire          FAULT_LOCKED,
	input  wire          FAULT_READ,
	input  wire          FAULT_SUPERVISOR,
	input  wire [1:0]    FAULT_ORIG_SIZE,
	input  wire [1:0]    FAULT_TYPE,
	input  wire [2:0]    FAULT_MODIFIER,
	input  wire [AW-1:0] FAULT_FIRST_LOGICAL,
	input  wire [AW-1:0] FAULT_PHYSICAL,
	input  wire          PEND_MULTI_MOVE,
	input  wire          PEND_TRACE,
	input  wire          PEND_FP_UNIMPL,
	input  wire          PEND_FP_POST,
	input  wire [AW-1:0] CALC_EA,
	input  wire [31:0]   INT_STAGE_RAW,
	input  wire [1:0]    INT_STAGE_SIZE,
	input  wire [31:0]   MEM_STAGE_RAW,
	input  wire [1:0]    MEM_STAGE_SIZE,
	input  wire [31:0]   BUS_STAGE_RAW,
	input  wire [1:0]    BUS_STAGE_SIZE,
	input  wire [1:0]    BUS_STAGE_LOW_ADDR,
	input  wire          BUS_STAGE_VALID,
	input  wire [127:0]  LINE_IMAGE,
	input  wire          ADDR_ERR_VALID,
	input  wire [AW-1:0] ADDR_ERR_PC,
	input  wire [AW-1:0] ADDR_ERR_REF,
	input  wire          RET_VALID,
	input  wire [3:0]    RET_FORMAT,
	input  wire [15:0]   RET_STATUS_WORD,
	input  wire [AW-1:0] RET_EA,
	input  wire [2:0]    RET_EA_MODE,
	input  wire [2:0]    RET_EA_REG,
	input  wire          RET_VALIDATE_FAULT,
	output reg           FRAME_VALID,
	output reg  [3:0]    FRAME_FORMAT,
	output reg  [15:0]   FRAME_STATUS_WORD,
	output reg  [AW-1:0] FRAME_EA,
	output reg  [AW-1:0] FRAME_FAULT_ADDR,
	output reg  [7:0]    FRAME_BUS_STATUS,
	output reg  [AW-1:0] FRAME_BUS_ADDR,
	output reg  [31:0]   FRAME_BUS_DATA,
	output reg  [31:0]   FRAME_MEM_DATA,
	output reg  [31:0]   FRAME_INT_DATA,
	output reg  [127:0]  FRAME_LINE_IMAGE,
	output reg  [AW-1:0] FRAME_PC,
	output reg           RET_DONE,
	output reg  [7:0]    RET_READ_LAST,
	output reg  [7:0]    RET_SP_ADD,
	output reg           RET_TRACE_MOVE,
	output reg  [7:0]    RET_MOVE_LAST,
	output reg  [3:0]    RET_NEW_FORMAT,
	output reg           RET_ENTER_TRACE,
	output reg           RET_ENTER_FP_POST,
	output reg           RET_ENTER_FP_UNIMPL,
	output reg           RET_RESTART_MOVE,
	output reg           RET_REUSE_EA,
	output reg           RET_EA_LOAD,
	output reg  [AW-1:0] RET_EA_OUT,
	output reg           RET_FORMAT_EXC,
	output reg           RET_KEEP_FRAME
);
////////////////////////////////////////////////////////////////////////////////
// Reset release through two flops
reg rst_meta;
reg rst_sync;
always @(posedge CLOCK or negedge RST_B)
begin
	if (!RST_B)
	begin
		rst_meta <= 1'b0;
		rst_sync <= 1'b0;
	end
	else
	begin
		rst_meta <= 1'b1;
		rst_sync <= rst_meta;
	end
end
wire rst_n = rst_sync;
////////////////////////////////////////////////////////////////////////////////
// Register aligned data: low bytes only
function [31:0] aefu_reg_align;
	input [31:0] raw;
	input [1:0]  size;
	begin
		case (size)
			`AEFU_SIZE_BYTE: aefu_reg_align = {24'h00_0000, raw[7:0]};
			`AEFU_SIZE_WORD: aefu_reg_align = {16'h0000, raw[15:0]};
			default:         aefu_reg_align = raw;
		endcase
	end
endfunction
// Lane placement: rotate right by 8 per low address step
function [31:0] aefu_lane_align;
	input [31:0] raw;
	input [1:0]  size;
	input [1:0]  low;
	reg   [31:0] left;
	begin
		case (size)
			`AEFU_SIZE_BYTE: left = {raw[7:0], 24'h00_0000};
			`AEFU_SIZE_WORD: left = {raw[15:0], 16'h0000};
			default:         left = raw;
		endcase
		case (low)
			2'h1:    aefu_lane_align = {left[7:0], left[31:8]};
			2'h2:    aefu_lane_align = {left[15:0], left[31:16]};
			2'h3:    aefu_lane_align = {left[23:0], left[31:24]};
			default: aefu_lane_align = left;
		endcase
	end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Frame build
reg [15:0] next_status;
reg        pend_cont;
always @*
begin
	next_status = 16'h0000;
	pend_cont = 1'b0;
	if (PEND_FP_POST)
		next_status[`AEFU_ST_FP_POST] = 1'b1;
	else if (PEND_FP_UNIMPL)
		next_status[`AEFU_ST_FP_UNIMPL] = 1'b1;
	else if (PEND_TRACE)
		next_status[`AEFU_ST_TRACE] = 1'b1;
	else if (PEND_MULTI_MOVE && !FAULT_IS_INSN)
		next_status[`AEFU_ST_MULTI_MOVE] = 1'b1;
	pend_cont = |next_status[15:12];
	next_status[`AEFU_ST_PAGE_SPAN] = FAULT_IS_TRANSLATION & FAULT_SECOND_PAGE;
	next_status[`AEFU_ST_XLATE] = FAULT_IS_TRANSLATION;
	next_status[`AEFU_ST_LOCKED] = FAULT_LOCKED;
	next_status[`AEFU_ST_READ] = FAULT_READ;
	next_status[`AEFU_ST_SIZE_LO+1:`AEFU_ST_SIZE_LO] = FAULT_ORIG_SIZE;
	next_status[`AEFU_ST_TYPE_LO+1:`AEFU_ST_TYPE_LO] = FAULT_TYPE;
	next_status[2:0] = FAULT_MODIFIER;
	if (FAULT_IS_INSN)
		next_status[2:0] = FAULT_SUPERVISOR ? `AEFU_MOD_SUPER_INSN : `AEFU_MOD_USER_INSN;
end
always @(posedge CLOCK or negedge rst_n)
begin
	if (!rst_n)
	begin
		FRAME_VALID      <= 1'b0;
		FRAME_FORMAT     <= 4'h0;
		FRAME_STATUS_WORD <= 16'h0000;
		FRAME_EA         <= {AW{1'b0}};
		FRAME_FAULT_ADDR <= {AW{1'b0}};
		FRAME_BUS_STATUS <= 8'h00;
		FRAME_BUS_ADDR   <= {AW{1'b0}};
		FRAME_BUS_DATA   <= 32'h0000_0000;
		FRAME_MEM_DATA   <= 32'h0000_0000;
		FRAME_INT_DATA   <= 32'h0000_0000;
		FRAME_LINE_IMAGE <= {128{1'b0}};
		FRAME_PC         <= {AW{1'b0}};
	end
	else
	begin
		FRAME_VALID <= 1'b0;
		if (FAULT_VALID)
		begin
			FRAME_VALID  <= 1'b1;
			FRAME_FORMAT <= `AEFU_FMT_ACCESS;
			FRAME_STATUS_WORD <= next_status;
			FRAME_EA     <= pend_cont ? CALC_EA : {AW{1'b0}};
			FRAME_FAULT_ADDR <= FAULT_IS_PUSH ? FAULT_PHYSICAL : FAULT_FIRST_LOGICAL;
			FRAME_BUS_STATUS <= (FAULT_IS_PUSH || FAULT_IS_LINE_MOVE_WR || FAULT_IS_INSN
				|| !BUS_STAGE_VALID) ? 8'h00 : 8'h80;
			FRAME_BUS_ADDR <= FAULT_IS_PUSH ? FAULT_PHYSICAL : FAULT_FIRST_LOGICAL;
			FRAME_BUS_DATA <= FAULT_IS_PUSH ? LINE_IMAGE[31:0]
				: aefu_lane_align(BUS_STAGE_RAW, BUS_STAGE_SIZE, BUS_STAGE_LOW_ADDR);
			FRAME_MEM_DATA <= FAULT_IS_INSN ? 32'h0000_0000
				: aefu_reg_align(MEM_STAGE_RAW, MEM_STAGE_SIZE);
			FRAME_INT_DATA <= FAULT_IS_INSN ? 32'h0000_0000
				: aefu_reg_align(INT_STAGE_RAW, INT_STAGE_SIZE);
			// Line image is already memory aligned
			FRAME_LINE_IMAGE <= LINE_IMAGE;
		end
		else if (ADDR_ERR_VALID)
		begin
			FRAME_VALID      <= 1'b1;
			FRAME_FORMAT     <= `AEFU_FMT_ADDR_ERR;
			FRAME_PC         <= ADDR_ERR_PC;
			FRAME_EA         <= {ADDR_ERR_REF[AW-1:1], 1'b0};
			FRAME_STATUS_WORD <= 16'h0000;
			FRAME_BUS_STATUS <= 8'h00;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// Exception return
wire ret_post   = RET_STATUS_WORD[`AEFU_ST_FP_POST];
wire ret_unimpl = RET_STATUS_WORD[`AEFU_ST_FP_UNIMPL];
wire ret_trace  = RET_STATUS_WORD[`AEFU_ST_TRACE];
wire ret_multi  = RET_STATUS_WORD[`AEFU_ST_MULTI_MOVE];
// Undefined combinations resolve by this fixed order
wire ret_legal = (RET_FORMAT == `AEFU_FMT_ACCESS);
always @(posedge CLOCK or negedge rst_n)
begin
	if (!rst_n)
	begin
		RET_DONE            <= 1'b0;
		RET_READ_LAST       <= 8'h00;
		RET_SP_ADD          <= 8'h00;
		RET_TRACE_MOVE      <= 1'b0;
		RET_MOVE_LAST       <= 8'h00;
		RET_NEW_FORMAT      <= 4'h0;
		RET_ENTER_TRACE     <= 1'b0;
		RET_ENTER_FP_POST   <= 1'b0;
		RET_ENTER_FP_UNIMPL <= 1'b0;
		RET_RESTART_MOVE    <= 1'b0;
		RET_REUSE_EA        <= 1'b0;
		RET_EA_LOAD         <= 1'b0;
		RET_EA_OUT          <= {AW{1'b0}};
		RET_FORMAT_EXC      <= 1'b0;
		RET_KEEP_FRAME      <= 1'b0;
	end
	else
	begin
		RET_DONE            <= 1'b0;
		RET_TRACE_MOVE      <= 1'b0;
		RET_ENTER_TRACE     <= 1'b0;
		RET_ENTER_FP_POST   <= 1'b0;
		RET_ENTER_FP_UNIMPL <= 1'b0;
		RET_RESTART_MOVE    <= 1'b0;
		RET_REUSE_EA        <= 1'b0;
		RET_EA_LOAD         <= 1'b0;
		RET_FORMAT_EXC      <= 1'b0;
		RET_KEEP_FRAME      <= 1'b0;
		if (RET_VALID)
		begin
			RET_DONE <= 1'b1;
			if (!ret_legal || RET_VALIDATE_FAULT)
			begin
				RET_FORMAT_EXC <= 1'b1;
				RET_KEEP_FRAME <= 1'b1;
				RET_SP_ADD     <= 8'h00;
			end
			else
			begin
				// Only words 0 through D read
				RET_READ_LAST <= `AEFU_RETURN_LAST;
				RET_SP_ADD    <= `AEFU_FRAME_BYTES;
				RET_EA_OUT    <= RET_EA;
				if (ret_trace)
				begin
					RET_TRACE_MOVE  <= 1'b1;
					RET_MOVE_LAST   <= `AEFU_TRACE_SRC_LAST;
					RET_SP_ADD      <= `AEFU_TRACE_SHIFT;
					RET_NEW_FORMAT  <= `AEFU_FMT_ADDR_ERR;
					RET_ENTER_TRACE <= 1'b1;
					RET_EA_LOAD     <= 1'b1;
				end
				else if (ret_post || ret_unimpl)
				begin
					RET_EA_LOAD         <= 1'b1;
					RET_ENTER_FP_POST   <= ret_post;
					RET_ENTER_FP_UNIMPL <= ~ret_post;
				end
				else if (ret_multi)
				begin
					RET_EA_LOAD      <= 1'b1;
					RET_RESTART_MOVE <= 1'b1;
					RET_REUSE_EA <= (RET_EA_MODE == `AEFU_MODE_INDEX) ||
						((RET_EA_MODE == `AEFU_MODE_PC_REL) &&
						((RET_EA_REG == `AEFU_REG_PC_DISP) ||
						(RET_EA_REG == `AEFU_REG_PC_INDEX)));
				end
			end
		end
	end
end
endmodule
`default_nettype wire

// ==== bench/aefu_monitor.sv ====
// Port checker for the access error frame unit
`default_nettype none
module aefu_monitor
#(
	parameter AW = 32
)
(
	input wire logic          CLOCK,
	input wire logic          RST_B,
	input wire logic          FAULT_VALID,
	input wire logic          FAULT_READ,
	input wire logic          FAULT_LOCKED,
	input wire logic          FAULT_IS_INSN,
	input wire logic          FAULT_SUPERVISOR,
	input wire logic          ADDR_ERR_VALID,
	input wire logic          RET_VALID,
	input wire logic [3:0]    RET_FORMAT,
	input wire logic [15:0]   RET_STATUS_WORD,
	input wire logic          RET_VALIDATE_FAULT,
	input wire logic          FRAME_VALID,
	input wire logic [3:0]    FRAME_FORMAT,
	input wire logic [15:0]   FRAME_STATUS_WORD,
	input wire logic [AW-1:0] FRAME_EA,
	input wire logic          RET_DONE,
	input wire logic [7:0]    RET_SP_ADD,
	input wire logic [3:0]    RET_NEW_FORMAT,
	input wire logic          RET_FORMAT_EXC,
	input wire logic          RET_KEEP_FRAME
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////////////////////////////////////
	// Legal return with no error path
	wire legal = RET_VALID && RET_FORMAT == 4'h7 && !RET_VALIDATE_FAULT;
	a_read_flag: assert property (FAULT_VALID |=>
		FRAME_STATUS_WORD[8] == $past(FAULT_READ))
		else $error("read flag wrong");
	a_locked_flag: assert property (FAULT_VALID |=>
		FRAME_STATUS_WORD[9] == $past(FAULT_LOCKED))
		else $error("locked flag wrong");
	a_one_cont: assert property (FRAME_VALID |->
		$countones(FRAME_STATUS_WORD[15:12]) <= 1)
		else $error("several continuation flags");
	a_insn_modifier: assert property (FAULT_VALID && FAULT_IS_INSN |=>
		FRAME_STATUS_WORD[2:0] == ($past(FAULT_SUPERVISOR) ? 3'h6 : 3'h2))
		else $error("instruction modifier wrong");
	a_trace_pop: assert property (legal && RET_STATUS_WORD[13] |=>
		RET_DONE && RET_SP_ADD == 8'h30 && RET_NEW_FORMAT == 4'h2)
		else $error("trace return wrong");
	a_plain_pop: assert property (legal && RET_STATUS_WORD[15:12] == 4'h0 |=>
		RET_SP_ADD == 8'h3C)
		else $error("plain return pop wrong");
	a_bad_format: assert property (RET_VALID && RET_FORMAT != 4'h7 |=>
		RET_FORMAT_EXC && RET_KEEP_FRAME && RET_SP_ADD == 8'h00)
		else $error("format exception missing");
	a_addr_error: assert property (ADDR_ERR_VALID && !FAULT_VALID |=>
		FRAME_VALID && FRAME_FORMAT == 4'h2 && !FRAME_EA[0])
		else $error("address error frame wrong");
	c_fault: cover property (FAULT_VALID ##1 FRAME_VALID);
	c_trace: cover property (legal && RET_STATUS_WORD[13]);
	c_addr: cover property (ADDR_ERR_VALID);
endmodule
bind aefu_frame_unit aefu_monitor #(.AW(AW)) mon_u (.*);
`default_nettype wire

// ==== bench/tb_access_error_frame_unit.sv ====
// Testbench for the access error frame unit
`default_nettype none
module tb_access_error_frame_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK=0, RST_B=0, FAULT_VALID=0, FAULT_IS_INSN=0, FAULT_IS_PUSH=0;
	logic FAULT_IS_LINE_MOVE_WR=0, FAULT_IS_TRANSLATION=0, FAULT_SECOND_PAGE=0;
	logic FAULT_LOCKED=0, FAULT_READ=0, FAULT_SUPERVISOR=0, PEND_MULTI_MOVE=0;
	logic PEND_TRACE=0, PEND_FP_UNIMPL=0, PEND_FP_POST=0, BUS_STAGE_VALID=0;
	logic ADDR_ERR_VALID=0, RET_VALID=0, RET_VALIDATE_FAULT=0;
	logic [1:0] FAULT_ORIG_SIZE=0, FAULT_TYPE=0, INT_STAGE_SIZE=0, MEM_STAGE_SIZE=0;
	logic [1:0] BUS_STAGE_SIZE=0, BUS_STAGE_LOW_ADDR=0;
	logic [2:0] FAULT_MODIFIER=0, RET_EA_MODE=0, RET_EA_REG=3'h2;
	logic [3:0] RET_FORMAT=0;
	logic [15:0] RET_STATUS_WORD=0;
	logic [31:0] FAULT_FIRST_LOGICAL=0, FAULT_PHYSICAL=0, CALC_EA=0, INT_STAGE_RAW=0;
	logic [31:0] MEM_STAGE_RAW=0, BUS_STAGE_RAW=0, ADDR_ERR_PC=0, ADDR_ERR_REF=0;
	logic [31:0] RET_EA=32'h0000_4444;
	logic [127:0] LINE_IMAGE=128'h1111_2222_3333_4444_5555_6666_7777_8888;
	logic FRAME_VALID, RET_DONE, RET_TRACE_MOVE, RET_ENTER_TRACE, RET_ENTER_FP_POST;
	logic RET_ENTER_FP_UNIMPL, RET_RESTART_MOVE, RET_REUSE_EA, RET_EA_LOAD;
	logic RET_FORMAT_EXC, RET_KEEP_FRAME;
	logic [3:0] FRAME_FORMAT, RET_NEW_FORMAT;
	logic [15:0] FRAME_STATUS_WORD;
	logic [7:0] FRAME_BUS_STATUS, RET_READ_LAST, RET_SP_ADD, RET_MOVE_LAST;
	logic [31:0] FRAME_EA, FRAME_FAULT_ADDR, FRAME_BUS_ADDR, FRAME_BUS_DATA, FRAME_PC;
	logic [31:0] FRAME_MEM_DATA, FRAME_INT_DATA, RET_EA_OUT;
	logic [127:0] FRAME_LINE_IMAGE;
	int mismatches = 0;
	int checks = 0;
	aefu_frame_unit dut_u (.*);
	initial
	begin
		forever #5 CLOCK = ~CLOCK;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Inputs move on falling edges; result read one cycle later
	task automatic pulse_fault(input logic a);
		@(negedge CLOCK);
		FAULT_VALID = !a;
		ADDR_ERR_VALID = a;
		@(negedge CLOCK);
		FAULT_VALID = 0;
		ADDR_ERR_VALID = 0;
	endtask
	task automatic ret(input logic [15:0] s, input logic [3:0] f, input logic v,
		input logic [2:0] m, input logic [7:0] sp, input logic [6:0] fl);
		@(negedge CLOCK);
		RET_VALID = 1;
		RET_STATUS_WORD = s;
		RET_FORMAT = f;
		RET_VALIDATE_FAULT = v;
		RET_EA_MODE = m;
		@(negedge CLOCK);
		RET_VALID = 0;
		chk({RET_DONE, RET_SP_ADD}, {1'b1, sp});
		chk({RET_ENTER_TRACE, RET_ENTER_FP_POST, RET_ENTER_FP_UNIMPL, RET_RESTART_MOVE,
			RET_REUSE_EA, RET_FORMAT_EXC, RET_KEEP_FRAME}, fl);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#20us;
		mismatches++;
		end_of_test;
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(negedge CLOCK);
		RST_B = 1;
		repeat (4) @(negedge CLOCK);
		FAULT_LOCKED = 1;
		FAULT_ORIG_SIZE = 2;
		FAULT_TYPE = 1;
		FAULT_MODIFIER = 5;
		FAULT_FIRST_LOGICAL = 32'h0000_1001;
		FAULT_PHYSICAL = 32'h0000_9000;
		BUS_STAGE_RAW = 32'h0000_ABCD;
		BUS_STAGE_SIZE = 2;
		BUS_STAGE_LOW_ADDR = 3;
		BUS_STAGE_VALID = 1;
		INT_STAGE_RAW = 32'h1234_5678;
		INT_STAGE_SIZE = 1;
		MEM_STAGE_RAW = 32'h1234_5678;
		MEM_STAGE_SIZE = 2;
		pulse_fault(0);
		chk({FRAME_VALID, FRAME_FORMAT, FRAME_STATUS_WORD}, {1'b1, 4'h7, 16'h024D});
		chk({FRAME_FAULT_ADDR, FRAME_BUS_ADDR}, {2{32'h0000_1001}});
		chk(FRAME_BUS_DATA, 32'hCD00_00AB);
		chk({FRAME_INT_DATA, FRAME_MEM_DATA}, {32'h0000_0078, 32'h0000_5678});
		chk(FRAME_BUS_STATUS, 8'h80);
		FAULT_LOCKED = 0;
		FAULT_IS_PUSH = 1;
		FAULT_TYPE = 0;
		FAULT_MODIFIER = 0;
		pulse_fault(0);
		chk({FRAME_FAULT_ADDR, FRAME_BUS_ADDR}, {2{32'h0000_9000}});
		chk({FRAME_BUS_STATUS, FRAME_STATUS_WORD[10]}, 9'h000);
		chk(FRAME_LINE_IMAGE, LINE_IMAGE);
		chk(FRAME_BUS_DATA, 32'h7777_8888);
		FAULT_IS_PUSH = 0;
		FAULT_IS_LINE_MOVE_WR = 1;
		pulse_fault(0);
		chk(FRAME_BUS_STATUS, 8'h00);
		FAULT_IS_LINE_MOVE_WR = 0;
		FAULT_IS_TRANSLATION = 1;
		FAULT_SECOND_PAGE = 1;
		FAULT_READ = 1;
		FAULT_ORIG_SIZE = 1;
		FAULT_MODIFIER = 1;
		PEND_MULTI_MOVE = 1;
		CALC_EA = 32'h0000_3000;
		pulse_fault(0);
		chk({FRAME_STATUS_WORD, FRAME_EA}, {16'h1D21, 32'h0000_3000});
		PEND_FP_POST = 1;
		pulse_fault(0);
		chk(FRAME_STATUS_WORD[15:12], 4'h8);
		PEND_FP_POST = 0;
		PEND_FP_UNIMPL = 1;
		pulse_fault(0);
		chk(FRAME_STATUS_WORD[15:12], 4'h4);
		PEND_FP_UNIMPL = 0;
		PEND_TRACE = 1;
		pulse_fault(0);
		chk({FRAME_STATUS_WORD[15:12], FRAME_EA}, {4'h2, 32'h0000_3000});
		PEND_TRACE = 0;
		PEND_MULTI_MOVE = 0;
		FAULT_IS_TRANSLATION = 0;
		FAULT_SECOND_PAGE = 0;
		FAULT_IS_INSN = 1;
		FAULT_SUPERVISOR = 1;
		FAULT_MODIFIER = 3;
		FAULT_FIRST_LOGICAL = 32'h0000_5000;
		pulse_fault(0);
		chk({FRAME_STATUS_WORD[2:0], FRAME_BUS_STATUS, FRAME_FAULT_ADDR},
			{3'h6, 8'h00, 32'h5000});
		chk({FRAME_INT_DATA, FRAME_MEM_DATA}, 64'h0000_0000_0000_0000);
		ADDR_ERR_PC = 32'h0000_0100;
		ADDR_ERR_REF = 32'h0000_2223;
		pulse_fault(1);
		chk({FRAME_FORMAT, FRAME_PC, FRAME_EA}, {4'h2, 32'h100, 32'h2222});
		ret(16'h0000, 4'h7, 0, 3'h0, 8'h3C, 7'b0000000);
		chk({RET_TRACE_MOVE, RET_EA_LOAD}, 2'b00);
		ret(16'h2000, 4'h7, 0, 3'h0, 8'h30, 7'b1000000);
		chk({RET_NEW_FORMAT, RET_MOVE_LAST, RET_READ_LAST}, {4'h2, 8'h0B, 8'h0D});
		chk({RET_TRACE_MOVE, RET_EA_LOAD}, 2'b11);
		ret(16'h8000, 4'h7, 0, 3'h0, 8'h3C, 7'b0100000);
		chk(RET_EA_OUT, 32'h0000_4444);
		ret(16'h4000, 4'h7, 0, 3'h0, 8'h3C, 7'b0010000);
		ret(16'h1000, 4'h7, 0, 3'h6, 8'h3C, 7'b0001100);
		ret(16'h1000, 4'h7, 0, 3'h7, 8'h3C, 7'b0001100);
		ret(16'h1000, 4'h7, 0, 3'h0, 8'h3C, 7'b0001000);
		chk({RET_EA_LOAD, RET_TRACE_MOVE}, 2'b10);
		RET_EA_REG = 3'h0;
		ret(16'h1000, 4'h7, 0, 3'h7, 8'h3C, 7'b0001000);
		ret(16'h0000, 4'h4, 0, 3'h0, 8'h00, 7'b0000011);
		ret(16'h0000, 4'h7, 1, 3'h0, 8'h00, 7'b0000011);
		end_of_test;
	end
endmodule
`default_nettype wire
